/* File: core/gdio_map.vh */
// Register map and reset values of the general digital I/O port.
// Assumes APB byte addressing with one 32-bit word per register.
`ifndef GDIO_MAP_VH
`define GDIO_MAP_VH
`define GDIO_OFF_VALUE 12'h000
`define GDIO_OFF_DIR 12'h004
`define GDIO_OFF_PIN 12'h008
`define GDIO_OFF_SFIO 12'h00C
`define GDIO_OFF_BITSET 12'h010
`define GDIO_OFF_BITCLR 12'h014
`define GDIO_SFIO_PUD_BIT 2
`define GDIO_RST_VALUE 8'h00
`define GDIO_RST_DIR 8'h00
`define GDIO_RST_PUD 1'b0
`define GDIO_SEL_VALUE 1'b0
`define GDIO_SEL_DIR 1'b1
`endif

/* File: core/gdio_sync.v */
// Pin-input synchroniser: falling-edge register, then a rising-edge register.
// Assumes pins and clock enable come from the system clock domain's boundary.
`default_nettype none
module gdio_sync #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] latch_reg;
  // Samples on the falling edge, holds until the next falling edge
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      latch_reg <= {WIDTH{1'b0}};
    end else if (ce) begin
      latch_reg <= d;
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= {WIDTH{1'b0}};
    end else if (ce) begin
      q <= latch_reg;
    end
  end
endmodule
`default_nettype wire

/* File: core/gdio_port.v */
// General digital I/O port: value, direction and pin-input registers over APB.
// Assumes APB signals are synchronous to CLK_SYS; pad wires resolved outside from PIN_OE_N.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`include "gdio_map.vh"
`default_nettype none
// Behaviour
// - Three registers per port: value, direction, pins
// - Pin register read-only; others read-write
// - Global disable kills every pull-up
// - Direction one output, zero input
// - Input with value one enables pull-up
// - Output drives value bit level
// - Reset tri-states pins without clock
// - Tri-state to high passes intermediate state
// - Pull-up only for dir0, value1, enable
// - Pin bit follows synchronised pin always
// - Latch high-transparent then rising register; here a falling-edge register stands in for the latch
// - Pin change visible half to 1.5 periods
// - Written value reaches pin bit in one period
// - Bit set/clear touch only addressed pin
// - Other pins usable beside alternate functions
// - Clock and pull-up disable shared by ports; here each port instance holds its own pull-up disable bit
// - Pull-up disable at bit two
module gdio_port #(
  parameter WIDTH = 8
) (
  input wire CLK_SYS,
  input wire RST,
  input wire CE,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire [WIDTH-1:0] PIN_IN,
  output wire [WIDTH-1:0] PIN_OUT,
  output wire [WIDTH-1:0] PIN_OE_N,
  output wire [WIDTH-1:0] PIN_PULLUP
);
  reg [WIDTH-1:0] value_reg;
  reg [WIDTH-1:0] dir_reg;
  reg pud_reg;
  reg [WIDTH-1:0] value_next;
  reg [WIDTH-1:0] dir_next;
  reg pud_next;
  reg [WIDTH-1:0] out_reg;
  reg [WIDTH-1:0] oe_n_reg;
  reg [WIDTH-1:0] pu_reg;
  reg [WIDTH-1:0] out_next;
  reg [WIDTH-1:0] oe_n_next;
  reg [WIDTH-1:0] pu_next;
  reg [31:0] rdata_next;
  reg ready_next;
  reg slverr_next;
  wire [WIDTH-1:0] pin_input;
  wire [WIDTH-1:0] op_mask;
  wire op_on_dir;
  wire setup;
  wire wr;
  wire rd;
  wire addr_mapped;
  wire write_value_strobe;
  wire write_direction_strobe;
  wire write_pud_strobe;
  wire bit_set_strobe;
  wire bit_clear_strobe;
  wire write_pin_strobe;
  wire read_value_strobe;
  wire read_direction_strobe;
  wire read_pin_strobe;
  wire read_pud_strobe;

  // Single-bit mask from a write-data index; out of range gives zero
  function [WIDTH-1:0] bit_mask;
    input [31:0] idx;
    begin
      bit_mask = (idx[7:0] < WIDTH) ? ({{(WIDTH-1){1'b0}}, 1'b1} << idx[7:0]) : {WIDTH{1'b0}};
    end
  endfunction

  // Every offset that answers without an error
  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `GDIO_OFF_VALUE) || (a == `GDIO_OFF_DIR) || (a == `GDIO_OFF_PIN) ||
                  (a == `GDIO_OFF_SFIO) || (a == `GDIO_OFF_BITSET) || (a == `GDIO_OFF_BITCLR);
    end
  endfunction

  // Exact match only: aliases would let a stray offset hit a register
  function addr_hit;
    input [11:0] a;
    input [11:0] off;
    begin
      addr_hit = (a == off);
    end
  endfunction

  // One-pin change; every other bit of the word keeps its value
  function [WIDTH-1:0] apply_bit;
    input [WIDTH-1:0] cur;
    input [WIDTH-1:0] mask;
    input set;
    begin
      if (set) begin
        apply_bit = cur | mask;
      end else begin
        apply_bit = cur & ~mask;
      end
    end
  endfunction

  // Pull-up only for an input with value one and the global disable clear
  function [WIDTH-1:0] pull_enable;
    input [WIDTH-1:0] dir;
    input [WIDTH-1:0] val;
    input global_pullup_disable;
    begin
      pull_enable = ~dir & val & {WIDTH{~global_pullup_disable}};
    end
  endfunction

  // Read words carry the port in the low bits, zeros above
  function [31:0] zero_ext;
    input [WIDTH-1:0] v;
    begin
      zero_ext = {{(32-WIDTH){1'b0}}, v};
    end
  endfunction

  // A transfer is taken at its setup edge; the access cycle only carries the answer
  assign setup = PSEL && !PENABLE;
  assign wr = setup && PWRITE;
  assign rd = setup && !PWRITE;
  assign addr_mapped = is_mapped(PADDR);

  // Strobes common to all pins of the port
  assign write_value_strobe = wr && addr_hit(PADDR, `GDIO_OFF_VALUE);
  assign write_direction_strobe = wr && addr_hit(PADDR, `GDIO_OFF_DIR);
  assign write_pud_strobe = wr && addr_hit(PADDR, `GDIO_OFF_SFIO);
  assign bit_set_strobe = wr && addr_hit(PADDR, `GDIO_OFF_BITSET);
  assign bit_clear_strobe = wr && addr_hit(PADDR, `GDIO_OFF_BITCLR);
  // Pin register is read-only: its write strobe reaches no state
  assign write_pin_strobe = wr && addr_hit(PADDR, `GDIO_OFF_PIN);
  assign read_value_strobe = rd && addr_hit(PADDR, `GDIO_OFF_VALUE);
  assign read_direction_strobe = rd && addr_hit(PADDR, `GDIO_OFF_DIR);
  assign read_pin_strobe = rd && addr_hit(PADDR, `GDIO_OFF_PIN);
  assign read_pud_strobe = rd && addr_hit(PADDR, `GDIO_OFF_SFIO);

  // Bit set/clear: PWDATA[7:0] index, PWDATA[8] selects direction register
  assign op_mask = bit_mask(PWDATA);
  assign op_on_dir = (PWDATA[8] == `GDIO_SEL_DIR);

  // Driven pads loop back through the pins, so a written level reads back one period later
  // Synchroniser runs on every pin whatever its direction
  gdio_sync #(.WIDTH(WIDTH)) u_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .ce(CE),
    .d(PIN_IN),
    .q(pin_input)
  );

  // Direction: whole-word write or one-pin set/clear
  always @* begin
    dir_next = dir_reg;
    if (write_direction_strobe) begin
      dir_next = PWDATA[WIDTH-1:0];
    end else if (bit_set_strobe && op_on_dir) begin
      dir_next = apply_bit(dir_reg, op_mask, 1'b1);
    end else if (bit_clear_strobe && op_on_dir) begin
      dir_next = apply_bit(dir_reg, op_mask, 1'b0);
    end
  end

  // Output value: same paths; the pin register address leaves it alone
  always @* begin
    value_next = value_reg;
    if (write_value_strobe) begin
      value_next = PWDATA[WIDTH-1:0];
    end else if (bit_set_strobe && !op_on_dir) begin
      value_next = apply_bit(value_reg, op_mask, 1'b1);
    end else if (bit_clear_strobe && !op_on_dir) begin
      value_next = apply_bit(value_reg, op_mask, 1'b0);
    end else if (write_pin_strobe) begin
      value_next = value_reg;
    end
  end

  // One disable bit serves every pin of this port
  always @* begin
    pud_next = pud_reg;
    if (write_pud_strobe) begin
      pud_next = PWDATA[`GDIO_SFIO_PUD_BIT];
    end
  end

  // Pads follow the next state so they move at the write edge itself
  always @* begin
    out_next = value_next;
    oe_n_next = ~dir_next;
    pu_next = pull_enable(dir_next, value_next, pud_next);
  end

  // Read mux; unmapped and write-only addresses return zero
  always @* begin
    rdata_next = 32'h00000000;
    if (read_value_strobe) begin
      rdata_next = zero_ext(value_reg);
    end else if (read_direction_strobe) begin
      rdata_next = zero_ext(dir_reg);
    end else if (read_pin_strobe) begin
      rdata_next = zero_ext(pin_input);
    end else if (read_pud_strobe) begin
      rdata_next = {31'h0, pud_reg} << `GDIO_SFIO_PUD_BIT;
    end
  end

  // Zero-wait APB: every taken transfer is answered in the access cycle
  always @* begin
    ready_next = setup;
    slverr_next = setup && !addr_mapped;
  end

  // Port state; clock enable low freezes everything
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      value_reg <= `GDIO_RST_VALUE;
    end else if (CE) begin
      value_reg <= value_next;
    end
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      dir_reg <= `GDIO_RST_DIR;
    end else if (CE) begin
      dir_reg <= dir_next;
    end
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pud_reg <= `GDIO_RST_PUD;
    end else if (CE) begin
      pud_reg <= pud_next;
    end
  end

  // Reset tri-states the pads at once, clock or not
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      out_reg <= {WIDTH{1'b0}};
    end else if (CE) begin
      out_reg <= out_next;
    end
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      oe_n_reg <= {WIDTH{1'b1}};
    end else if (CE) begin
      oe_n_reg <= oe_n_next;
    end
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pu_reg <= {WIDTH{1'b0}};
    end else if (CE) begin
      pu_reg <= pu_next;
    end
  end

  // Answer registers; data stay zero outside the access cycle
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h00000000;
    end else if (CE) begin
      PRDATA <= rdata_next;
    end
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
    end else if (CE) begin
      PREADY <= ready_next;
    end
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PSLVERR <= slverr_next;
    end
  end

  assign PIN_OUT = out_reg;
  assign PIN_OE_N = oe_n_reg;
  assign PIN_PULLUP = pu_reg;
endmodule
`default_nettype wire

/* File: tb/gdio_chk.sv */
// Checker of the port: APB answer timing and pad relations.
// Assumes a bind to gdio_port with WIDTH 8.
`default_nettype none
module gdio_chk(
  input wire CLK_SYS,
  input wire RST,
  input wire CE,
  input wire PSEL,
  input wire PENABLE,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire [7:0] PIN_OE_N,
  input wire [7:0] PIN_PULLUP
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  wire st = PSEL && !PENABLE && CE;
  a_ready_late: assert property (st |=> PREADY) else $error("late ready");
  a_ready_held: assert property (PREADY |=> !PREADY) else $error("ready held");
  a_ready_stray: assert property (!PSEL |=> !PREADY) else $error("stray ready");
  a_error_alone: assert property (PSLVERR |-> PREADY) else $error("lone error");
  a_data_idle: assert property (!PREADY |-> PRDATA == 32'h0) else $error("stray data");
  a_pads_hold: assert property (!st |=> $stable(PIN_OE_N) && $stable(PIN_PULLUP)) else $error("pad moved");
  a_pull_excl: assert property ((PIN_PULLUP & ~PIN_OE_N) == 8'h0) else $error("pull on output");
  a_reset_tri: assert property (disable iff (1'b0) RST |-> (PIN_OE_N & ~PIN_PULLUP) == 8'hFF) else $error("tri");
endmodule
`default_nettype wire

/* File: tb/gdio_ext.sv */
// Far-side pads: port drive wins, then outside drive, then pull-up.
// Assumes outside drivers are strong and low.
`default_nettype none
module gdio_ext(
  input wire [7:0] pin_out,
  input wire [7:0] oe_n,
  input wire [7:0] pu_en,
  input wire [7:0] ext_en,
  output logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Floating pad reads inverse of drive value, so no steady guess passes
  assign pin_in = ~oe_n & pin_out | oe_n & ~ext_en & (pu_en | ~pin_out);
endmodule
`default_nettype wire

/* File: tb/gdio_port_tb.sv */
// Bench of gdio_port: APB scenarios with the far-side pad model.
// Assumes gdio_chk and gdio_ext compiled first.
`include "gdio_map.vh"
`default_nettype none
module gdio_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst, sel = 0, en = 0, wr = 0, rdy, err;
  logic [11:0] ad = 0;
  logic [31:0] wd = 0, rd, got;
  logic [7:0] po, oe, pu, pi, ee = 8'hFF;
  int failures = 0, cmp_count = 0;
  always #25 clk = ~clk;
  gdio_port DUT(.CLK_SYS(clk), .RST(rst), .CE(1'b1), .PSEL(sel), .PENABLE(en), .PWRITE(wr), .PADDR(ad),
    .PWDATA(wd), .PRDATA(rd), .PREADY(rdy), .PSLVERR(err), .PIN_IN(pi), .PIN_OUT(po), .PIN_OE_N(oe), .PIN_PULLUP(pu));
  gdio_ext EXT(.pin_out(po), .oe_n(oe), .pu_en(pu), .ext_en(ee), .pin_in(pi));
  task automatic chk(input string n, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    int i;
    @(posedge clk);
    sel <= 1;
    wr <= w;
    ad <= a;
    wd <= d;
    @(posedge clk);
    en <= 1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rdy !== 1'b1 && i < 20);
    if (rdy !== 1'b1) begin
      failures++;
      complete_run;
    end
    got = rd;
    chk("err", {7'h0, e}, {7'h0, err});
    sel <= 0;
    en <= 0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    apb(0, a, 32'h0, 1'b0);
    chk("read", e, got[7:0]);
  endtask
  task automatic t_drive;
    rdc(`GDIO_OFF_VALUE, 8'h00);
    rdc(`GDIO_OFF_DIR, 8'h00);
    ee <= 8'h50;
    apb(1, `GDIO_OFF_VALUE, 32'hA5, 1'b0);
    apb(1, `GDIO_OFF_DIR, 32'h0F, 1'b0);
    chk("oe", 8'hF0, oe);
    chk("out", 8'h05, po & 8'h0F);
    chk("pull", 8'hA0, pu);
    rdc(`GDIO_OFF_PIN, 8'hA5);
  endtask
  task automatic t_pud;
    apb(1, `GDIO_OFF_SFIO, 32'h4, 1'b0);
    chk("pull", 8'h00, pu);
    apb(1, `GDIO_OFF_SFIO, 32'h0, 1'b0);
    chk("pull", 8'hA0, pu);
  endtask
  task automatic t_bits;
    apb(1, `GDIO_OFF_BITSET, 32'h104, 1'b0);
    apb(1, `GDIO_OFF_BITCLR, 32'h0, 1'b0);
    rdc(`GDIO_OFF_DIR, 8'h1F);
    rdc(`GDIO_OFF_VALUE, 8'hA4);
    apb(1, `GDIO_OFF_PIN, 32'hFF, 1'b0);
    chk("oe", 8'hE0, oe);
    apb(0, 12'h020, 32'h0, 1'b1);
    chk("bad", 8'h00, got[7:0]);
  endtask
  initial begin
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    chk("oe", 8'hFF, oe);
    rst <= 0;
    t_drive;
    t_pud;
    t_bits;
    complete_run;
  end
endmodule
bind gdio_port gdio_chk CHK(.*);
`default_nettype wire
